/* File: rtl/sfb_pkg.sv */
// Package for the safety status flag bank: read commands, flag
// positions, register field layout and the monitored-condition carrier.
// Assumes one 10 MHz clock domain and an 8-bit serial read data path.
package sfb_pkg;

  // Read command codes of the serial front end (values arbitrary)
  localparam logic [7:0] CMD_RD_BUCK2_TEMP  = 8'h21;
  localparam logic [7:0] CMD_RD_STEPUP_FLT  = 8'h22;
  localparam logic [7:0] CMD_RD_STEPUP_TEMP = 8'h23;
  localparam logic [7:0] CMD_RD_SAFETY_ERR  = 8'h24;

  // Internal flag vector width and positions
  localparam int unsigned NFLAG = 13;
  localparam int unsigned F_B2_WARN  = 0;
  localparam int unsigned F_B2_SD    = 1;
  localparam int unsigned F_SU_SCG   = 2;
  localparam int unsigned F_SU_OVL   = 3;
  localparam int unsigned F_SU_SINK  = 4;
  localparam int unsigned F_SU_OVP   = 5;
  localparam int unsigned F_SU_GND   = 6;
  localparam int unsigned F_SU_WARN  = 7;
  localparam int unsigned F_SU_SD    = 8;
  localparam int unsigned F_IRQ_RB   = 9;
  localparam int unsigned F_RST_RB   = 10;
  localparam int unsigned F_NVM_CRC  = 11;
  localparam int unsigned F_CFG_CRC  = 12;

  // Flags that a read of each register may clear
  localparam logic [12:0] MASK_BUCK2_TEMP  = 13'h0003;
  localparam logic [12:0] MASK_STEPUP_FLT  = 13'h007c;
  localparam logic [12:0] MASK_STEPUP_TEMP = 13'h0180;
  localparam logic [12:0] MASK_SAFETY_ERR  = 13'h1e00;

  // Register field positions
  localparam int unsigned B_OT_WARN   = 0;
  localparam int unsigned B_OT_SD     = 1;
  localparam int unsigned B_SCG       = 0;
  localparam int unsigned B_OVL       = 1;
  localparam int unsigned B_SINK      = 2;
  localparam int unsigned B_OVP       = 3;
  localparam int unsigned B_GND       = 4;
  localparam int unsigned B_SPI_LO    = 0;
  localparam int unsigned B_IRQ_RB    = 2;
  localparam int unsigned B_RST_RB    = 3;
  localparam int unsigned B_NVM_CRC   = 4;
  localparam int unsigned B_CFG_CRC   = 5;

  // Reset values
  localparam logic [7:0]  RST_REG   = 8'h00;
  localparam logic [12:0] RST_FLAGS = 13'h0000;
  localparam logic [1:0]  RST_SPI   = 2'h0;

  // Serial error field encodings
  localparam logic [1:0] SPI_OK      = 2'h0;
  localparam logic [1:0] SPI_CMD_ERR = 2'h1;
  localparam logic [1:0] SPI_FMT_ERR = 2'h2;
  localparam logic [1:0] SPI_DO_ERR  = 2'h3;

  // Synchroniser depth and width for pin inputs
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned NMON        = 11;

  // Asynchronous monitor and read-back pins, one bit each
  typedef struct packed {
    logic reset_readback;
    logic irq_readback;
    logic step_up_overtemp_shutdown;
    logic step_up_overtemp_warning;
    logic step_up_ground_loss;
    logic step_up_overvoltage;
    logic step_up_highside_sink_limit;
    logic step_up_overload;
    logic step_up_short_to_ground;
    logic second_buck_overtemp_shutdown;
    logic second_buck_overtemp_warning;
  } sfb_mon_t;

endpackage : sfb_pkg

/* File: rtl/sfb_sync.sv */
// Three-stage synchroniser with agreement filter for a vector of pins.
// Assumes inputs are asynchronous to clk_i; output follows a change once
// the second and third stages agree.
`timescale 1ns/1ns
module sfb_sync #(
  parameter int unsigned W = 11
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // Stage chain; first stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= async_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  // Accept a bit only where stages two and three agree
  assign out_d  = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
  assign sync_o = out_q;

endmodule : sfb_sync

/* File: rtl/sfb_flag_bank.sv */
// Safety status flag bank: four read-only, read-to-clear status
// registers reached through dedicated serial read commands.
// Assumes a serial front end on clk_i that decodes frames and presents
// one-cycle read and write strobes plus frame error reports.
`timescale 1ns/1ns
module sfb_flag_bank (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Asynchronous monitor and read-back pins
  input  sfb_pkg::sfb_mon_t     mon_i,
  // Driven levels of the two checked output drivers
  input  wire logic             reset_output_n_i,
  input  wire logic             enable_drive_irq_output_i,
  // Checksum results from on-chip logic
  input  wire logic [7:0]       config_crc_calc_i,
  input  wire logic [7:0]       config_checksum_expected_i,
  input  wire logic [7:0]       nvm_crc_calc_i,
  input  wire logic [7:0]       nvm_crc_programmed_i,
  // Serial frame error report
  input  wire logic             spi_err_stb_i,
  input  wire logic [1:0]       spi_err_code_i,
  // Serial command port
  input  wire logic             rd_stb_i,
  input  wire logic             wr_stb_i,
  input  wire logic [7:0]       cmd_i,
  output logic                  rd_valid_o,
  output logic [7:0]            rd_data_o,
  output logic                  cmd_refused_o
);

  logic [sfb_pkg::NMON-1:0]  mon_s;
  sfb_pkg::sfb_mon_t         mon;
  logic [3:0]                rst_drv_q;
  logic [3:0]                irq_drv_q;
  logic [sfb_pkg::NFLAG-1:0] cond_vec;
  logic [sfb_pkg::NFLAG-1:0] clr_vec;
  logic [sfb_pkg::NFLAG-1:0] flags_q;
  logic [sfb_pkg::NFLAG-1:0] flags_d;
  logic [1:0]                spi_err_q;
  logic [1:0]                spi_err_d;
  logic [7:0]                rd_data_q;
  logic [7:0]                rd_data_d;
  logic                      rd_valid_q;
  logic                      refused_q;
  logic [7:0]                reg_b2_temp;
  logic [7:0]                reg_su_flt;
  logic [7:0]                reg_su_temp;
  logic [7:0]                reg_err;
  logic                      sel_b2;
  logic                      sel_flt;
  logic                      sel_sut;
  logic                      sel_err;
  logic                      sel_any;
  logic                      rd_take;
  logic                      err_read;
  logic                      spi_new;

  // Pin synchroniser for monitors and read-back
  sfb_sync #(
    .W (sfb_pkg::NMON)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (mon_i),
    .sync_o  (mon_s)
  );

  assign mon = sfb_pkg::sfb_mon_t'(mon_s);

  // Delay driven levels by the synchroniser's four-edge latency, so a
  // legal level change does not flag a false mismatch; both paths
  // leave reset at zero so no false mismatch follows reset either
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_drv_q <= 4'h0;
      irq_drv_q <= 4'h0;
    end else begin
      rst_drv_q <= {rst_drv_q[2:0], reset_output_n_i};
      irq_drv_q <= {irq_drv_q[2:0], enable_drive_irq_output_i};
    end
  end

  // Monitored conditions, one per flag
  assign cond_vec[sfb_pkg::F_B2_WARN] =
    mon.second_buck_overtemp_warning;
  assign cond_vec[sfb_pkg::F_B2_SD]   =
    mon.second_buck_overtemp_shutdown;
  assign cond_vec[sfb_pkg::F_SU_SCG]  = mon.step_up_short_to_ground;
  assign cond_vec[sfb_pkg::F_SU_OVL]  = mon.step_up_overload;
  assign cond_vec[sfb_pkg::F_SU_SINK] =
    mon.step_up_highside_sink_limit;
  assign cond_vec[sfb_pkg::F_SU_OVP]  = mon.step_up_overvoltage;
  assign cond_vec[sfb_pkg::F_SU_GND]  = mon.step_up_ground_loss;
  assign cond_vec[sfb_pkg::F_SU_WARN] =
    mon.step_up_overtemp_warning;
  assign cond_vec[sfb_pkg::F_SU_SD]   =
    mon.step_up_overtemp_shutdown;
  assign cond_vec[sfb_pkg::F_IRQ_RB]  =
    mon.irq_readback ^ irq_drv_q[3];
  assign cond_vec[sfb_pkg::F_RST_RB]  =
    mon.reset_readback ^ rst_drv_q[3];
  assign cond_vec[sfb_pkg::F_NVM_CRC] =
    nvm_crc_calc_i != nvm_crc_programmed_i;
  assign cond_vec[sfb_pkg::F_CFG_CRC] =
    config_crc_calc_i != config_checksum_expected_i;

  // Command decode; writes and unknown codes are refused
  assign sel_b2  = cmd_i == sfb_pkg::CMD_RD_BUCK2_TEMP;
  assign sel_flt = cmd_i == sfb_pkg::CMD_RD_STEPUP_FLT;
  assign sel_sut = cmd_i == sfb_pkg::CMD_RD_STEPUP_TEMP;
  assign sel_err = cmd_i == sfb_pkg::CMD_RD_SAFETY_ERR;
  assign sel_any = sel_b2 | sel_flt | sel_sut | sel_err;
  assign rd_take  = rd_stb_i & sel_any;
  assign err_read = rd_take & sel_err;

  // Read-clear mask of the addressed register
  assign clr_vec = rd_take ?
    (({sfb_pkg::NFLAG{sel_b2}}  & sfb_pkg::MASK_BUCK2_TEMP)  |
     ({sfb_pkg::NFLAG{sel_flt}} & sfb_pkg::MASK_STEPUP_FLT)  |
     ({sfb_pkg::NFLAG{sel_sut}} & sfb_pkg::MASK_STEPUP_TEMP) |
     ({sfb_pkg::NFLAG{sel_err}} & sfb_pkg::MASK_SAFETY_ERR))
    : '0;

  // Per-flag latch: condition sets, read clears only when condition gone
  for (genvar i = 0; i < sfb_pkg::NFLAG; i++) begin : g_flag
    assign flags_d[i] = cond_vec[i] | (flags_q[i] & ~clr_vec[i]);
  end

  // Serial error field: newest error wins; read clears if none arrives
  assign spi_new   = spi_err_stb_i & (spi_err_code_i != sfb_pkg::SPI_OK);
  assign spi_err_d = spi_new  ? spi_err_code_i :
                     err_read ? sfb_pkg::SPI_OK :
                     spi_err_q;

  // Register images; reserved bits read zero
  assign reg_b2_temp = {6'h00,
    flags_q[sfb_pkg::F_B2_SD], flags_q[sfb_pkg::F_B2_WARN]};
  assign reg_su_flt  = {3'h0,
    flags_q[sfb_pkg::F_SU_GND], flags_q[sfb_pkg::F_SU_OVP],
    flags_q[sfb_pkg::F_SU_SINK], flags_q[sfb_pkg::F_SU_OVL],
    flags_q[sfb_pkg::F_SU_SCG]};
  assign reg_su_temp = {6'h00,
    flags_q[sfb_pkg::F_SU_SD], flags_q[sfb_pkg::F_SU_WARN]};
  assign reg_err     = {2'h0,
    flags_q[sfb_pkg::F_CFG_CRC], flags_q[sfb_pkg::F_NVM_CRC],
    flags_q[sfb_pkg::F_RST_RB], flags_q[sfb_pkg::F_IRQ_RB],
    spi_err_q};

  // Read data mux from pre-clear flag values
  assign rd_data_d = ({8{sel_b2}}  & reg_b2_temp) |
                     ({8{sel_flt}} & reg_su_flt)  |
                     ({8{sel_sut}} & reg_su_temp) |
                     ({8{sel_err}} & reg_err);

  // Flag and serial error state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q   <= sfb_pkg::RST_FLAGS;
      spi_err_q <= sfb_pkg::RST_SPI;
    end else begin
      flags_q   <= flags_d;
      spi_err_q <= spi_err_d;
    end
  end

  // Read answer; data captured on the same edge the clear lands
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q  <= sfb_pkg::RST_REG;
      rd_valid_q <= 1'b0;
      refused_q  <= 1'b0;
    end else begin
      rd_data_q  <= rd_take ? rd_data_d : rd_data_q;
      rd_valid_q <= rd_take;
      refused_q  <= wr_stb_i | (rd_stb_i & ~sel_any);
    end
  end

  assign rd_valid_o    = rd_valid_q;
  assign rd_data_o     = rd_data_q;
  assign cmd_refused_o = refused_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Helper: command of the previous cycle
  logic [7:0] cmd_prev_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_prev_q <= 8'h00;
    end else begin
      cmd_prev_q <= cmd_i;
    end
  end

  AST_FLAG_HOLDS: assert property (
    1'b1 |=> ((($past(flags_q) & ~$past(clr_vec)) & ~flags_q) == '0))
    else $error("flag dropped without a read");

  AST_CLEAR_ON_READ: assert property (
    rd_take |=> ((flags_q & $past(clr_vec) & ~$past(cond_vec)) == '0))
    else $error("flag not cleared by read after condition gone");

  AST_PERSIST: assert property (
    1'b1 |=> (($past(cond_vec) & ~flags_q) == '0))
    else $error("flag not set while condition present");

  AST_WRITE_NO_EFFECT: assert property (
    (wr_stb_i && !rd_take && cond_vec == '0) |=>
      (flags_q == $past(flags_q) && !rd_valid_o && cmd_refused_o))
    else $error("write altered flags or was answered");

  AST_READ_OLD_VALUE: assert property (
    (rd_take && sel_flt) |=>
      (rd_valid_o && rd_data_o[4:0] == {$past(flags_q[6]),
        $past(flags_q[5]), $past(flags_q[4]), $past(flags_q[3]),
        $past(flags_q[2])}))
    else $error("read data not the pre-read flag values");

  AST_RESERVED_ZERO: assert property (
    (rd_valid_o && (cmd_prev_q == sfb_pkg::CMD_RD_BUCK2_TEMP ||
                    cmd_prev_q == sfb_pkg::CMD_RD_STEPUP_TEMP))
      |-> rd_data_o[7:2] == 6'h00)
    else $error("reserved bits of temperature register not zero");

  AST_SPI_CAPTURE: assert property (
    spi_new |=> spi_err_q == $past(spi_err_code_i))
    else $error("serial error code not captured");

  AST_SPI_HOLD: assert property (
    (!spi_new && !err_read) |=> spi_err_q == $past(spi_err_q))
    else $error("serial error field changed without read");

  AST_CFG_CRC: assert property (
    (config_crc_calc_i != config_checksum_expected_i) |=>
      flags_q[sfb_pkg::F_CFG_CRC] ##1
      (flags_q[sfb_pkg::F_CFG_CRC] || $past(err_read)))
    else $error("configuration checksum flag not set");

  AST_NVM_CRC: assert property (
    (nvm_crc_calc_i != nvm_crc_programmed_i) |=> flags_q[sfb_pkg::F_NVM_CRC])
    else $error("nonvolatile checksum flag not set");

  AST_RST_RB: assert property (
    (mon.reset_readback != rst_drv_q[3]) |=> flags_q[sfb_pkg::F_RST_RB])
    else $error("reset driver read-back flag not set");

  AST_IRQ_RB: assert property (
    (mon.irq_readback != irq_drv_q[3]) |=> flags_q[sfb_pkg::F_IRQ_RB])
    else $error("enable drive read-back flag not set");

  AST_GND_LOSS: assert property (
    mon.step_up_ground_loss |=> flags_q[sfb_pkg::F_SU_GND])
    else $error("ground loss flag not set");

  AST_FLT_RESERVED: assert property (
    (rd_valid_o && cmd_prev_q == sfb_pkg::CMD_RD_STEPUP_FLT)
      |-> rd_data_o[7:5] == 3'h0)
    else $error("reserved bits of fault register not zero");

  AST_OVP: assert property (
    mon.step_up_overvoltage |=> flags_q[sfb_pkg::F_SU_OVP])
    else $error("overvoltage flag not set");

  AST_SINK: assert property (
    mon.step_up_highside_sink_limit |=> flags_q[sfb_pkg::F_SU_SINK])
    else $error("sink current limit flag not set");

  AST_OVERLOAD: assert property (
    mon.step_up_overload |=> flags_q[sfb_pkg::F_SU_OVL])
    else $error("overload flag not set");

  AST_SHORT: assert property (
    mon.step_up_short_to_ground |=> flags_q[sfb_pkg::F_SU_SCG])
    else $error("short to ground flag not set");

  AST_SU_SHUTDOWN: assert property (
    mon.step_up_overtemp_shutdown |=> flags_q[sfb_pkg::F_SU_SD])
    else $error("step-up shutdown flag not set");

  AST_SU_WARNING: assert property (
    mon.step_up_overtemp_warning |=> flags_q[sfb_pkg::F_SU_WARN])
    else $error("step-up warning flag not set");

  COV_READ_SET_FLAG: cover property (
    rd_take && sel_flt && flags_q[sfb_pkg::F_SU_OVP] ##1 rd_valid_o);
  COV_CLEAR_AND_CONFIRM: cover property (
    rd_take && sel_b2 && flags_q[sfb_pkg::F_B2_SD] ##[1:20]
    rd_take && sel_b2 && !flags_q[sfb_pkg::F_B2_SD]);
  COV_SPI_FORMAT: cover property (
    spi_err_stb_i && spi_err_code_i == sfb_pkg::SPI_FMT_ERR ##[1:20]
    err_read);
  COV_WRITE_REFUSED: cover property (wr_stb_i ##1 cmd_refused_o);

endmodule : sfb_flag_bank

/* File: dv/sfb_host_model.sv */
// Host controller model issuing serial read and write commands.
// Assumes requests launch 1 ns after a rising edge of clk_i.
`timescale 1ns/1ns
module sfb_host_model (
  input  wire logic       clk_i,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       refused_i,
  output logic            rd_stb_o,
  output logic            wr_stb_o,
  output logic [7:0]      cmd_o
);
  // Idle bus; the code lines show a pattern, not a stale value
  initial begin
    rd_stb_o = 1'b0;
    wr_stb_o = 1'b0;
    cmd_o    = 8'h5a;
  end

  // One read; answer and refusal taken one edge after the request
  task automatic rd(input logic [7:0] c, output logic [7:0] d,
                    output logic v, output logic r);
    @(posedge clk_i);
    #1 rd_stb_o = 1'b1;
    cmd_o = c;
    @(posedge clk_i);
    #1 rd_stb_o = 1'b0;
    cmd_o = ~c;
    v = rd_valid_i;
    d = rd_data_i;
    r = refused_i;
  endtask : rd

  // One write attempt; the registers have no writable field
  task automatic wr(input logic [7:0] c, output logic r);
    @(posedge clk_i);
    #1 wr_stb_o = 1'b1;
    cmd_o = c;
    @(posedge clk_i);
    #1 wr_stb_o = 1'b0;
    cmd_o = ~c;
    r = refused_i;
  endtask : wr
endmodule : sfb_host_model

/* File: dv/tb_top.sv */
// Self-checking bench for the safety status flag bank.
// Assumes the host model drives the command port; bench drives the rest.
`timescale 1ns/1ns
module tb_top;
  logic              clk_i;
  logic              rst_i;
  sfb_pkg::sfb_mon_t mon;
  logic              rst_lvl;
  logic              irq_lvl;
  logic [7:0]        cfg_calc;
  logic [7:0]        nvm_calc;
  logic [7:0]        cfg_exp;
  logic [7:0]        nvm_prog;
  logic              err_stb;
  logic [1:0]        err_code;
  logic              rd_stb, wr_stb, rd_valid, refused;
  logic [7:0]        cmd, rd_data;
  int                err_count = 0;
  int                samples_checked = 0;

  sfb_flag_bank sfb_flag_bank_inst (
    .clk_i(clk_i), .rst_i(rst_i), .mon_i(mon),
    .reset_output_n_i(rst_lvl), .enable_drive_irq_output_i(irq_lvl),
    .config_crc_calc_i(cfg_calc), .config_checksum_expected_i(cfg_exp),
    .nvm_crc_calc_i(nvm_calc), .nvm_crc_programmed_i(nvm_prog),
    .spi_err_stb_i(err_stb), .spi_err_code_i(err_code),
    .rd_stb_i(rd_stb), .wr_stb_i(wr_stb), .cmd_i(cmd),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .cmd_refused_o(refused));

  sfb_host_model sfb_host_model_inst (
    .clk_i(clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .refused_i(refused), .rd_stb_o(rd_stb), .wr_stb_o(wr_stb),
    .cmd_o(cmd));

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(input string n, input logic [7:0] e,
                       input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : check

  // Wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  // Read a register and compare valid, refusal and data
  task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    logic       v, r;
    sfb_host_model_inst.rd(c, d, v, r);
    check("read valid", 8'h01, {7'h00, v});
    check("read refused", 8'h00, {7'h00, r});
    check("read data", e, d);
  endtask : rd_chk

  // Pulse one serial error report
  task automatic spi_err(input logic [1:0] c);
    err_stb = 1'b1;
    err_code = c;
    cyc(1);
    err_stb = 1'b0;
    cyc(1);
  endtask : spi_err

  task automatic t_reset;
    rd_chk(sfb_pkg::CMD_RD_BUCK2_TEMP, 8'h00);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_FLT, 8'h00);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_TEMP, 8'h00);
    rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, 8'h00);
    mon.second_buck_overtemp_warning = 1'b1;
    cyc(6);
    mon.second_buck_overtemp_warning = 1'b0;
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    cyc(6);
    rd_chk(sfb_pkg::CMD_RD_BUCK2_TEMP, 8'h00);
  endtask : t_reset

  // Latched pulse: first read shows it, second read confirms clear
  task automatic t_buck2;
    mon.second_buck_overtemp_shutdown = 1'b1;
    mon.second_buck_overtemp_warning = 1'b1;
    cyc(6);
    mon.second_buck_overtemp_shutdown = 1'b0;
    mon.second_buck_overtemp_warning = 1'b0;
    cyc(10);
    rd_chk(sfb_pkg::CMD_RD_BUCK2_TEMP, 8'h03);
    rd_chk(sfb_pkg::CMD_RD_BUCK2_TEMP, 8'h00);
  endtask : t_buck2

  // Conditions still present survive the read
  task automatic t_stepup;
    mon.step_up_ground_loss = 1'b1;
    mon.step_up_overvoltage = 1'b1;
    mon.step_up_highside_sink_limit = 1'b1;
    mon.step_up_overload = 1'b1;
    mon.step_up_short_to_ground = 1'b1;
    mon.step_up_overtemp_shutdown = 1'b1;
    cyc(6);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_FLT, 8'h1f);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_FLT, 8'h1f);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_TEMP, 8'h02);
    mon.step_up_ground_loss = 1'b0;
    mon.step_up_overvoltage = 1'b0;
    mon.step_up_highside_sink_limit = 1'b0;
    mon.step_up_overload = 1'b0;
    mon.step_up_short_to_ground = 1'b0;
    mon.step_up_overtemp_shutdown = 1'b0;
    mon.step_up_overtemp_warning = 1'b1;
    cyc(6);
    mon.step_up_overtemp_warning = 1'b0;
    cyc(6);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_FLT, 8'h1f);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_FLT, 8'h00);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_TEMP, 8'h03);
    rd_chk(sfb_pkg::CMD_RD_STEPUP_TEMP, 8'h00);
  endtask : t_stepup

  // Checksum and driver read-back mismatches
  task automatic t_errors;
    cfg_calc = 8'h5b;
    nvm_calc = 8'hc2;
    mon.reset_readback = 1'b0;
    mon.irq_readback = 1'b1;
    cyc(8);
    cfg_calc = 8'h5a;
    nvm_calc = 8'hc3;
    mon.reset_readback = 1'b1;
    mon.irq_readback = 1'b0;
    cyc(8);
    rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, 8'h3c);
    rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, 8'h00);
    rst_lvl = 1'b0;
    irq_lvl = 1'b1;
    mon.reset_readback = 1'b0;
    mon.irq_readback = 1'b1;
    cyc(8);
    rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, 8'h00);
    cfg_exp = 8'h11;
    nvm_prog = 8'h22;
    cyc(2);
    cfg_exp = 8'h5a;
    nvm_prog = 8'hc3;
    cyc(2);
    rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, 8'h30);
    rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, 8'h00);
  endtask : t_errors

  // Every serial error code, newest wins, code zero ignored
  task automatic t_spi;
    for (int i = 1; i < 4; i++) begin
      spi_err(i[1:0]);
      cyc(20);
      rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, {6'h00, i[1:0]});
      rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, 8'h00);
    end
    spi_err(sfb_pkg::SPI_CMD_ERR);
    spi_err(sfb_pkg::SPI_FMT_ERR);
    spi_err(sfb_pkg::SPI_OK);
    rd_chk(sfb_pkg::CMD_RD_SAFETY_ERR, 8'h02);
  endtask : t_spi

  // Writes and unknown codes are refused and leave flags alone
  task automatic t_refuse;
    logic [7:0] d;
    logic       v, r;
    mon.second_buck_overtemp_warning = 1'b1;
    cyc(6);
    mon.second_buck_overtemp_warning = 1'b0;
    cyc(6);
    sfb_host_model_inst.wr(sfb_pkg::CMD_RD_BUCK2_TEMP, r);
    check("write refused", 8'h01, {7'h00, r});
    sfb_host_model_inst.rd(8'h7f, d, v, r);
    check("bad code valid", 8'h00, {7'h00, v});
    check("bad code refused", 8'h01, {7'h00, r});
    rd_chk(sfb_pkg::CMD_RD_BUCK2_TEMP, 8'h01);
    rd_chk(sfb_pkg::CMD_RD_BUCK2_TEMP, 8'h00);
  endtask : t_refuse

  // Watchdog
  initial begin
    cyc(5000);
    err_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    mon = '0;
    mon.reset_readback = 1'b1;
    rst_lvl = 1'b1;
    irq_lvl = 1'b0;
    cfg_calc = 8'h5a;
    nvm_calc = 8'hc3;
    cfg_exp = 8'h5a;
    nvm_prog = 8'hc3;
    err_stb = 1'b0;
    err_code = 2'h0;
    cyc(20);
    rst_i = 1'b0;
    cyc(6);
    t_reset();
    t_buck2();
    t_stepup();
    t_refuse();
    t_spi();
    t_errors();
    end_of_test();
  end
endmodule : tb_top
